// >>> hdl/tx_cell_pkg.sv
package tx_cell_pkg;
   // Sizes of the write interface
   localparam int NUM_CHAN = 4;
   localparam int CH_W = 2;
   localparam int BUS_W = 64;
   localparam int REG_ADDR_W = 10;
   localparam int REG_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int FREE_W = 5;
   localparam int WORD_W = BUS_W + 1;

   // Channel setup register, offset within each channel page
   localparam logic [7:0] SETUP_OFFSET = 8'h40;
   localparam logic [15:0] SETUP_RESET = 16'h0119;
   localparam int POLARITY_POS = 10;
   localparam int CFG_W = POLARITY_POS + 1;
   localparam int SYNC_W = NUM_CHAN * CFG_W + 1;

   // Cell shape on the 64-bit bus
   localparam logic [5:0] CELL_WORDS_PLAIN = 6'h07;
   localparam logic [5:0] CELL_WORDS_SPACER = 6'h08;
   localparam logic [5:0] SPACER_WORD = 6'h02;
   localparam logic [5:0] DROP_MARGIN = 6'h03;
   localparam logic [5:0] WORD_IDX_MAX = 6'h3F;
   localparam logic [FREE_W-1:0] CELL_STORE = 5'h07;
   localparam logic [FREE_W-1:0] LAST_SLOT_FREE = 5'h0E;
   localparam logic [1:0] DROP_LAG = 2'h3;

   // Field layout matches register bits 10..0
   typedef struct packed {
      logic polarity;
      logic paritySense;
      logic delaySel;
      logic flush;
      logic spacer;
      logic [5:0] dropIdx;
   } chan_cfg_t;

   typedef struct packed {
      logic frameStart;
      logic [BUS_W-1:0] data;
   } cell_word_t;

   typedef enum logic {WR_CLOSED, WR_OPEN} wr_state_t;

   localparam chan_cfg_t SETUP_RESET_CFG = chan_cfg_t'(SETUP_RESET[CFG_W-1:0]);

   // Words on the bus for one cell
   function automatic logic [5:0] cellWords(input logic spacer);
      return spacer ? CELL_WORDS_SPACER : CELL_WORDS_PLAIN;
   endfunction : cellWords

   // Word whose sampling starts the flag drop; code 0 and codes above 3 fall back to n-3
   function automatic logic [5:0] dropWord(input logic [5:0] idx, input logic [5:0] n);
      logic [5:0] late;
      late = n - DROP_MARGIN;
      return (idx != 6'h00 && idx <= DROP_MARGIN) ? idx : late;
   endfunction : dropWord
endpackage : tx_cell_pkg

// >>> hdl/cell_fifo.sv
`timescale 1ns/1ps
module cell_fifo #(
   parameter int WIDTH = 65,
   parameter int DEPTH = 16
) (
   input wire logic wClk,
   input wire logic wRst,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [WIDTH-1:0] wrData,
   output logic [$clog2(DEPTH):0] wrFree,
   input wire logic rClk,
   input wire logic rRst,
   input wire logic rdFlush,
   output logic rdValid,
   input wire logic rdReady,
   output logic [WIDTH-1:0] rdData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wBin_ff, wGray_ff, rBin_ff, rGray_ff;
   logic [AW:0] rGrayS1_ff, rGrayS2_ff, wGrayS1_ff, wGrayS2_ff;
   logic [AW:0] wUsed, wNext, rNext;
   logic rdValid_ff, empty, pop;
   logic [WIDTH-1:0] rdData_ff;

   function automatic logic [AW:0] toGray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : toGray

   function automatic logic [AW:0] fromGray(input logic [AW:0] g);
      logic [AW:0] b;
      b = g;
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : fromGray

   // Write side view of occupancy; read pointer may lag, so free is pessimistic
   assign wUsed = wBin_ff - fromGray(rGrayS2_ff);
   assign wrReady = wUsed != (AW+1)'(DEPTH);
   assign wrFree = (AW+1)'(DEPTH) - wUsed;
   assign wNext = wBin_ff + (AW+1)'(1);

   // Write pointer and storage, link clock
   always_ff @(posedge wClk) begin
      if (wRst) begin
         wBin_ff <= '0;
         wGray_ff <= '0;
      end else if (wrValid && wrReady) begin
         mem_ff[wBin_ff[AW-1:0]] <= wrData;
         wBin_ff <= wNext;
         wGray_ff <= toGray(wNext);
      end
   end

   // Gray pointer crossings, two flops each
   always_ff @(posedge wClk) begin
      rGrayS1_ff <= rGray_ff;
      rGrayS2_ff <= rGrayS1_ff;
   end

   always_ff @(posedge rClk) begin
      wGrayS1_ff <= wGray_ff;
      wGrayS2_ff <= wGrayS1_ff;
   end

   // Read side; a flush keeps popping and throws the words away
   assign empty = rBin_ff == fromGray(wGrayS2_ff);
   assign pop = !empty && (rdFlush || !rdValid_ff || rdReady);
   assign rNext = rBin_ff + (AW+1)'(1);

   always_ff @(posedge rClk) begin
      if (rRst) begin
         rBin_ff <= '0;
         rGray_ff <= '0;
         rdValid_ff <= 1'b0;
         rdData_ff <= '0;
      end else begin
         if (pop) begin
            rBin_ff <= rNext;
            rGray_ff <= toGray(rNext);
            rdData_ff <= mem_ff[rBin_ff[AW-1:0]];
         end
         if (rdFlush) begin
            rdValid_ff <= 1'b0;
         end else if (pop) begin
            rdValid_ff <= 1'b1;
         end else if (rdReady) begin
            rdValid_ff <= 1'b0;
         end
      end
   end

   assign rdValid = rdValid_ff;
   assign rdData = rdData_ff;
endmodule : cell_fifo

// >>> hdl/tx_cell_if_channel_config.sv
`timescale 1ns/1ps
// Operation
// - Single mode: all channels take channel 0 settings, except flush.
// - Each channel owns its flush bit, acting on its own FIFO only.
// - Polarity bit 0: available flags high mean room; bit 1: active low.
// - Parity input checked odd when sense bit 0, even when 1.
// - Poll response delay one cycle when delay bit 0, two when 1.
// - While flush set, its FIFO emptied and all writes to that channel ignored.
// - After flush clears, writes stay closed until first frame start.
// - Spacer bit 0: header directly followed by payload, 7 words.
// - Spacer bit 1: one unused word after header, 8 words.
// - Last-slot cell drops available flags 3 cycles after index word.
// - Index n-3 makes the flags drop at the edge that takes the last word.
module tx_cell_if_channel_config (
   input wire logic clk,
   input wire logic rst,
   input wire logic [tx_cell_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [tx_cell_pkg::REG_W-1:0] regWrData,
   output logic [tx_cell_pkg::REG_W-1:0] regRdData,
   input wire logic txInterfaceClock,
   input wire logic txQuadModeSelect,
   input wire logic txWriteEnableN,
   input wire logic [tx_cell_pkg::CH_W-1:0] txAddress,
   input wire logic [tx_cell_pkg::CH_W-1:0] txPollAddress,
   input wire logic [tx_cell_pkg::BUS_W-1:0] txDataBus,
   input wire logic txParityIn,
   input wire logic txFrameStart,
   output logic polledSpaceAvailable,
   output logic selectedSpaceAvailable,
   output logic [tx_cell_pkg::NUM_CHAN-1:0] directSpaceAvailable,
   output logic parityError,
   output tx_cell_pkg::cell_word_t [tx_cell_pkg::NUM_CHAN-1:0] cellOut,
   output logic [tx_cell_pkg::NUM_CHAN-1:0] cellValid,
   input wire logic [tx_cell_pkg::NUM_CHAN-1:0] cellReady
);
   localparam int N = tx_cell_pkg::NUM_CHAN;
   localparam int CW = tx_cell_pkg::CFG_W;
   localparam int SW = tx_cell_pkg::SYNC_W;
   localparam int FW = tx_cell_pkg::FREE_W;
   localparam logic [SW-1:0] TX_CFG_RESET = {1'b0, {N{tx_cell_pkg::SETUP_RESET_CFG}}};

   tx_cell_pkg::chan_cfg_t cfg_ff [N];
   logic [tx_cell_pkg::REG_W-1:0] regRdData_ff;
   logic regHit;
   logic [tx_cell_pkg::CH_W-1:0] regCh;
   logic [N-1:0] flushSys;

   // Register decode: channel in the page bits, setup register at one offset
   assign regHit = regAddr[7:0] == tx_cell_pkg::SETUP_OFFSET;
   assign regCh = regAddr[tx_cell_pkg::REG_ADDR_W-1:8];

   // Setup registers, one per channel
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < N; i++) begin
            cfg_ff[i] <= tx_cell_pkg::SETUP_RESET_CFG;
         end
      end else if (regWrite && regHit) begin
         cfg_ff[regCh] <= tx_cell_pkg::chan_cfg_t'(regWrData[CW-1:0]);
      end
   end

   // Read port; unmapped reads return zero, data holds until next read
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData_ff <= 16'h0000;
      end else if (regRead && regHit) begin
         regRdData_ff <= {5'h00, cfg_ff[regCh]};
      end else if (regRead) begin
         regRdData_ff <= 16'h0000;
      end
   end

   assign regRdData = regRdData_ff;

   // Flush bits seen by the drain side of each FIFO
   always_comb begin
      for (int i = 0; i < N; i++) begin
         flushSys[i] = cfg_ff[i].flush;
      end
   end

   logic [SW-1:0] syncIn, cfgS1_ff, cfgS2_ff, cfgS3_ff, txCfg_ff, agree;
   logic rstS1_ff, rstS2_ff, rstS3_ff, txRst_ff;

   // Settings and mode pin gathered for the link clock
   always_comb begin
      syncIn[SW-1] = txQuadModeSelect;
      for (int i = 0; i < N; i++) begin
         syncIn[i*CW +: CW] = cfg_ff[i];
      end
   end

   // Reset crossing; taken once the last two stages agree
   always_ff @(posedge txInterfaceClock) begin
      rstS1_ff <= rst;
      rstS2_ff <= rstS1_ff;
      rstS3_ff <= rstS2_ff;
   end

   always_ff @(posedge txInterfaceClock) begin
      if (rstS2_ff == rstS3_ff) begin
         txRst_ff <= rstS3_ff;
      end
   end

   // Settings are quasi static, so a per-bit crossing is enough
   always_ff @(posedge txInterfaceClock) begin
      cfgS1_ff <= syncIn;
      cfgS2_ff <= cfgS1_ff;
      cfgS3_ff <= cfgS2_ff;
   end

   assign agree = ~(cfgS2_ff ^ cfgS3_ff);

   always_ff @(posedge txInterfaceClock) begin
      if (txRst_ff) begin
         txCfg_ff <= TX_CFG_RESET;
      end else begin
         txCfg_ff <= (agree & cfgS3_ff) | (~agree & txCfg_ff);
      end
   end

   logic quadTx;
   tx_cell_pkg::chan_cfg_t chanCfg [N];
   tx_cell_pkg::chan_cfg_t effCfg [N];

   // Settings in force per channel
   always_comb begin
      quadTx = txCfg_ff[SW-1];
      for (int i = 0; i < N; i++) begin
         chanCfg[i] = tx_cell_pkg::chan_cfg_t'(txCfg_ff[i*CW +: CW]);
      end
      for (int i = 0; i < N; i++) begin
         effCfg[i] = quadTx ? chanCfg[i] : chanCfg[0];
         effCfg[i].flush = chanCfg[i].flush;
      end
   end

   logic [tx_cell_pkg::CH_W-1:0] selCh_ff, pollQ_ff, addrCh, pollCh;
   logic wrTake;

   // Single mode talks to channel 0 only
   assign addrCh = quadTx ? txAddress : 2'h0;
   assign pollCh = quadTx ? txPollAddress : 2'h0;
   assign wrTake = !txWriteEnableN;

   // Channel selection is taken while the enable is high
   always_ff @(posedge txInterfaceClock) begin
      if (txRst_ff) begin
         selCh_ff <= 2'h0;
      end else if (txWriteEnableN) begin
         selCh_ff <= addrCh;
      end
   end

   logic [5:0] wordIdx_ff, nxtWordIdx, selWords;
   tx_cell_pkg::chan_cfg_t selCfg;
   logic lastWord;

   // Word position within the cell, first word is 1
   assign nxtWordIdx = txFrameStart ? 6'h01 :
                       (wordIdx_ff == tx_cell_pkg::WORD_IDX_MAX) ? wordIdx_ff : wordIdx_ff + 6'h01;
   assign selCfg = effCfg[selCh_ff];
   assign selWords = tx_cell_pkg::cellWords(selCfg.spacer);
   assign lastWord = wrTake && nxtWordIdx == selWords;

   always_ff @(posedge txInterfaceClock) begin
      if (txRst_ff) begin
         wordIdx_ff <= 6'h00;
      end else if (wrTake) begin
         wordIdx_ff <= nxtWordIdx;
      end
   end

   tx_cell_pkg::wr_state_t wrState_ff [N];
   logic [N-1:0] inCell_ff, room_ff, dropFlag_ff, accept, push, dropTrig, wrReady, avail, availPol;
   logic [1:0] dropCnt_ff [N];
   logic [FW-1:0] free [N];
   logic [FW-1:0] freeStart_ff [N];
   logic [FW-1:0] startFree [N];

   // Per channel acceptance, spacer discard and drop trigger
   always_comb begin
      for (int i = 0; i < N; i++) begin
         accept[i] = wrTake && selCh_ff == 2'(i) && !effCfg[i].flush &&
                     (wrState_ff[i] == tx_cell_pkg::WR_OPEN || txFrameStart);
         push[i] = accept[i] && wrReady[i] &&
                   !(effCfg[i].spacer && nxtWordIdx == tx_cell_pkg::SPACER_WORD);
         startFree[i] = txFrameStart ? free[i] : freeStart_ff[i];
         dropTrig[i] = accept[i] && startFree[i] < tx_cell_pkg::LAST_SLOT_FREE &&
                       nxtWordIdx == tx_cell_pkg::dropWord(effCfg[i].dropIdx,
                                                           tx_cell_pkg::cellWords(effCfg[i].spacer));
         avail[i] = room_ff[i] && !dropFlag_ff[i] && !effCfg[i].flush;
         availPol[i] = avail[i] ^ effCfg[i].polarity;
      end
   end

   // Write gate; also closed after reset until a frame start
   always_ff @(posedge txInterfaceClock) begin
      for (int i = 0; i < N; i++) begin
         if (txRst_ff || effCfg[i].flush) begin
            wrState_ff[i] <= tx_cell_pkg::WR_CLOSED;
         end else begin
            case (wrState_ff[i])
               tx_cell_pkg::WR_CLOSED: begin
                  if (accept[i]) begin
                     wrState_ff[i] <= tx_cell_pkg::WR_OPEN;
                  end
               end
               tx_cell_pkg::WR_OPEN: begin
                  wrState_ff[i] <= tx_cell_pkg::WR_OPEN;
               end
               default: begin
                  wrState_ff[i] <= tx_cell_pkg::WR_CLOSED;
               end
            endcase
         end
      end
   end

   // Cell tracking and room at cell boundaries
   always_ff @(posedge txInterfaceClock) begin
      for (int i = 0; i < N; i++) begin
         if (txRst_ff || effCfg[i].flush) begin
            inCell_ff[i] <= 1'b0;
            freeStart_ff[i] <= 5'h00;
            room_ff[i] <= 1'b0;
         end else begin
            if (accept[i] && txFrameStart) begin
               inCell_ff[i] <= 1'b1;
               freeStart_ff[i] <= free[i];
            end else if (accept[i] && lastWord) begin
               inCell_ff[i] <= 1'b0;
            end
            if (!inCell_ff[i]) begin
               room_ff[i] <= free[i] >= tx_cell_pkg::CELL_STORE;
            end
         end
      end
   end

   // Drop timer; the set beats the clear in the same cycle
   always_ff @(posedge txInterfaceClock) begin
      for (int i = 0; i < N; i++) begin
         if (txRst_ff) begin
            dropCnt_ff[i] <= 2'h0;
            dropFlag_ff[i] <= 1'b0;
         end else begin
            if (dropTrig[i]) begin
               dropCnt_ff[i] <= tx_cell_pkg::DROP_LAG - 2'h1;
            end else if (dropCnt_ff[i] != 2'h0) begin
               dropCnt_ff[i] <= dropCnt_ff[i] - 2'h1;
            end
            if (dropCnt_ff[i] == 2'h1) begin
               dropFlag_ff[i] <= 1'b1;
            end else if (effCfg[i].flush || (!inCell_ff[i] && free[i] >= tx_cell_pkg::CELL_STORE)) begin
               dropFlag_ff[i] <= 1'b0;
            end
         end
      end
   end

   logic parityError_ff, polled_ff, selected_ff, delay2;
   logic [N-1:0] direct_ff;
   logic pollNow, pollLate;

   // Interface-wide poll delay follows channel 0
   assign delay2 = effCfg[0].delaySel;
   assign pollNow = availPol[pollCh];
   assign pollLate = availPol[pollQ_ff];

   // Parity over the whole data bus
   always_ff @(posedge txInterfaceClock) begin
      if (txRst_ff) begin
         parityError_ff <= 1'b0;
      end else begin
         parityError_ff <= wrTake && ((^{txDataBus, txParityIn}) == selCfg.paritySense);
      end
   end

   // Flag outputs, all registered
   always_ff @(posedge txInterfaceClock) begin
      if (txRst_ff) begin
         pollQ_ff <= 2'h0;
         polled_ff <= 1'b0;
         selected_ff <= 1'b0;
         direct_ff <= '0;
      end else begin
         pollQ_ff <= pollCh;
         polled_ff <= delay2 ? pollLate : pollNow;
         selected_ff <= availPol[selCh_ff];
         direct_ff <= availPol;
      end
   end

   assign parityError = parityError_ff;
   assign polledSpaceAvailable = polled_ff;
   assign selectedSpaceAvailable = selected_ff;
   assign directSpaceAvailable = direct_ff;

   tx_cell_pkg::cell_word_t wordIn;
   assign wordIn = '{frameStart: txFrameStart, data: txDataBus};

   // One FIFO per channel, written on the link clock, drained on clk
   for (genvar g = 0; g < N; g++) begin : gen_fifo
      cell_fifo #(
         .WIDTH(tx_cell_pkg::WORD_W),
         .DEPTH(tx_cell_pkg::FIFO_DEPTH)
      ) u_fifo (
         .wClk(txInterfaceClock),
         .wRst(txRst_ff),
         .wrValid(push[g]),
         .wrReady(wrReady[g]),
         .wrData(wordIn),
         .wrFree(free[g]),
         .rClk(clk),
         .rRst(rst),
         .rdFlush(flushSys[g]),
         .rdValid(cellValid[g]),
         .rdReady(cellReady[g]),
         .rdData(cellOut[g])
      );
   end

   // Drop timing steps on channel 0
   sequence s_drop_wait;
      !dropFlag_ff[0] ##1 !dropFlag_ff[0] ##1 dropFlag_ff[0];
   endsequence

   sequence s_drop_seen;
      directSpaceAvailable[0] == effCfg[0].polarity;
   endsequence

   a_drop_sel_flag: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      dropFlag_ff[0] && selCh_ff == 2'h0 |=> selectedSpaceAvailable == $past(effCfg[0].polarity))
      else $error("selected flag did not drop with the drop flag");

   a_drop_lag_exact: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      dropTrig[0] && !dropFlag_ff[0] && !effCfg[0].flush |=> s_drop_wait ##1 s_drop_seen)
      else $error("available flag did not drop three cycles after index word");

   a_single_mode_cfg: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      !quadTx |=> directSpaceAvailable[3] == ($past(avail[3]) ^ $past(chanCfg[0].polarity)))
      else $error("single mode settings not taken from channel 0");

   a_flush_per_chan: assert property (@(posedge clk) disable iff (rst)
      regWrite && regHit && regCh != 2'h0 |=> cfg_ff[0].flush == $past(cfg_ff[0].flush))
      else $error("flush of another channel touched channel 0");

   a_polarity_low: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      avail[0] && effCfg[0].polarity |=> !directSpaceAvailable[0])
      else $error("active low flag not low with room");

   a_parity_good: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      wrTake && ((^{txDataBus, txParityIn}) != selCfg.paritySense) |=> !parityError)
      else $error("good parity flagged as error");

   a_resp_one_cycle: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      !delay2 |=> polledSpaceAvailable == $past(pollNow))
      else $error("one cycle poll response wrong");

   a_flush_no_push: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      effCfg[0].flush |-> !push[0] ##1 !inCell_ff[0])
      else $error("write taken during flush");

   a_reopen_on_sof: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      wrState_ff[0] == tx_cell_pkg::WR_CLOSED && wrTake && !txFrameStart |-> !push[0])
      else $error("write taken before frame start");

   a_cell_plain_end: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      accept[0] && !effCfg[0].spacer && nxtWordIdx == 6'h07 |=> !inCell_ff[0])
      else $error("plain cell did not end at word 7");

   a_spacer_skip: assert property (@(posedge txInterfaceClock) disable iff (txRst_ff)
      accept[0] && effCfg[0].spacer && nxtWordIdx == 6'h02 |-> !push[0])
      else $error("spacer word stored");

   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      regRead |=> regRdData[15:11] == 5'h00)
      else $error("reserved bits read nonzero");
endmodule : tx_cell_if_channel_config

// >>> sim/atm_writer_model.sv
`timescale 1ns/1ps
module atm_writer_model (
   input wire logic txInterfaceClock,
   output logic txWriteEnableN,
   output logic [tx_cell_pkg::CH_W-1:0] txAddress,
   output logic [tx_cell_pkg::BUS_W-1:0] txDataBus,
   output logic txParityIn,
   output logic txFrameStart
);
   // Idle bus starts quiet
   initial begin
      txWriteEnableN = 1'b1;
      txAddress = '0;
      txDataBus = '0;
      txParityIn = 1'b0;
      txFrameStart = 1'b0;
   end

   // One cell; channel shown with enable high one edge before the first word
   task automatic sendCell(input logic [1:0] ch, input int n, input logic sense, input logic bad, input logic sof);
      @(posedge txInterfaceClock) #1;
      txAddress = ch;
      for (int i = 1; i <= n; i++) begin
         @(posedge txInterfaceClock) #1;
         txWriteEnableN = 1'b0;
         txDataBus = {30'h0, ch, 32'(i)};
         txParityIn = (^txDataBus) ^ !sense ^ bad;
         txFrameStart = sof && (i == 1);
      end
      @(posedge txInterfaceClock) #1;
      txWriteEnableN = 1'b1;
      txFrameStart = 1'b0;
      // Released bus inverts, so a late sample cannot pass as data
      txDataBus = ~txDataBus;
      txParityIn = ~txParityIn;
   endtask : sendCell
endmodule : atm_writer_model

// >>> sim/tx_cell_if_channel_config_bench.sv
`timescale 1ns/1ps
module tx_cell_if_channel_config_bench;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic rst = 1'b1;
   logic [tx_cell_pkg::REG_ADDR_W-1:0] regAddr = '0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regWrData = '0;
   logic [15:0] regRdData;
   logic quad = 1'b1;
   logic weN;
   logic [1:0] txAddr;
   logic [1:0] pollAddr = '0;
   logic [63:0] tx_data_bus;
   logic parIn;
   logic sof;
   logic polled;
   logic selected;
   logic [3:0] direct;
   logic parityError;
   tx_cell_pkg::cell_word_t [3:0] cellOut;
   logic [3:0] cellValid;
   logic [3:0] cellReady = 4'hF;
   int mismatches = 0;
   int check_count = 0;
   int words[4] = '{0, 0, 0, 0};
   int starts[4] = '{0, 0, 0, 0};
   int perrs = 0;
   logic [63:0] lastData[4];

   // Half periods of 25 and 6 keep the two clocks from ever sharing a rising edge
   always #25 clk = ~clk;
   always #6 linkClk = ~linkClk;

   tx_cell_if_channel_config u_tx_cell_if_channel_config (.clk(clk), .rst(rst), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
      .txInterfaceClock(linkClk), .txQuadModeSelect(quad), .txWriteEnableN(weN), .txAddress(txAddr),
      .txPollAddress(pollAddr), .txDataBus(tx_data_bus), .txParityIn(parIn), .txFrameStart(sof),
      .polledSpaceAvailable(polled), .selectedSpaceAvailable(selected), .directSpaceAvailable(direct),
      .parityError(parityError), .cellOut(cellOut), .cellValid(cellValid), .cellReady(cellReady));
   atm_writer_model u_atm_writer_model (.txInterfaceClock(linkClk), .txWriteEnableN(weN), .txAddress(txAddr),
      .txDataBus(tx_data_bus), .txParityIn(parIn), .txFrameStart(sof));

   // Drained words and parity pulses
   always @(posedge clk) begin
      for (int c = 0; c < 4; c++) begin
         if (cellValid[c] === 1'b1 && cellReady[c] === 1'b1) begin
            words[c]++;
            starts[c] += cellOut[c].frameStart;
            lastData[c] = cellOut[c].data;
         end
      end
   end
   always @(posedge linkClk) if (parityError === 1'b1) perrs++;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chkCount(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         mismatches++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chkCount
   task automatic regWr(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk) #1;
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(posedge clk) #1;
      regWrite = 1'b0;
   endtask : regWr
   task automatic regRd(input logic [9:0] a, input logic [15:0] exp);
      @(posedge clk) #1;
      regAddr = a;
      regRead = 1'b1;
      @(posedge clk) #1;
      regRead = 1'b0;
      chk(regRdData, exp);
   endtask : regRd
   task automatic linkWait(input int n);
      repeat (n) @(posedge linkClk);
      #1;
   endtask : linkWait
   // Bounded wait; running out counts a mismatch and ends the run
   task automatic waitWords(input int ch, input int n);
      for (int k = 0; k < 300 && words[ch] < n; k++) @(posedge clk);
      if (words[ch] < n) begin
         mismatches++;
         $display("[FAIL] %0t timeout draining channel %0d", $time, ch);
         final_report();
      end
      repeat (20) @(posedge clk);
   endtask : waitWords

   task automatic testRegs;
      for (int c = 0; c < 4; c++) regRd({c[1:0], 8'h40}, tx_cell_pkg::SETUP_RESET);
      regRd(10'h041, 16'h0000);
      regWr(10'h140, 16'hFFFF);
      regRd(10'h140, 16'h07FF);
      linkWait(8);
      chk(16'(direct[1]), 16'h0001);
      chk(16'(direct[0]), 16'h0001);
      regWr(10'h140, 16'h0519);
      linkWait(8);
      chk(16'(direct[1]), 16'h0000);
      regWr(10'h140, 16'h0119);
      $display("registers and polarity done");
   endtask : testRegs

   task automatic testFlush;
      regWr(10'h240, 16'h0199);
      linkWait(8);
      u_atm_writer_model.sendCell(2, 7, 0, 0, 1);
      u_atm_writer_model.sendCell(1, 7, 0, 0, 0);
      regWr(10'h240, 16'h0119);
      // Nothing may arrive, so a fixed wait instead of a word count
      repeat (40) @(posedge clk);
      chkCount(words[2], 0);
      chkCount(words[1], 0);
      u_atm_writer_model.sendCell(1, 7, 0, 0, 1);
      waitWords(1, 7);
      chkCount(words[1], 7);
      chkCount(starts[1], 1);
      $display("flush done");
   endtask : testFlush

   task automatic testFill;
      // Early drop index 2 exercises the as-is index codes
      regWr(10'h040, 16'h0102);
      linkWait(8);
      @(posedge clk) #1;
      cellReady[0] = 1'b0;
      for (int i = 0; i < 3; i++) u_atm_writer_model.sendCell(0, 7, 0, 0, 1);
      linkWait(4);
      chk(16'(direct[0]), 16'h0000);
      chk(16'(selected), 16'h0000);
      @(posedge clk) #1;
      cellReady[0] = 1'b1;
      // Drain register holds one word beyond the FIFO depth
      waitWords(0, tx_cell_pkg::FIFO_DEPTH + 1);
      chkCount(words[0], tx_cell_pkg::FIFO_DEPTH + 1);
      chkCount(starts[0], 3);
      linkWait(10);
      chk(16'(direct[0]), 16'h0001);
      $display("fill done");
   endtask : testFill

   task automatic testSpacer;
      regWr(10'h240, 16'h0159);
      linkWait(8);
      u_atm_writer_model.sendCell(2, 8, 0, 0, 1);
      waitWords(2, 7);
      chkCount(words[2], 7);
      chk(lastData[2][15:0], 16'h0008);
      regWr(10'h240, 16'h0119);
      $display("spacer done");
   endtask : testSpacer

   task automatic testParity;
      for (int s = 0; s < 2; s++) begin
         regWr(10'h040, s ? 16'h0319 : 16'h0119);
         linkWait(8);
         perrs = 0;
         u_atm_writer_model.sendCell(0, 7, s[0], 1, 1);
         u_atm_writer_model.sendCell(0, 7, s[0], 0, 1);
         linkWait(4);
         chkCount(perrs, 7);
      end
      regWr(10'h040, 16'h0119);
      $display("parity done");
   endtask : testParity

   task automatic testPoll;
      regWr(10'h340, 16'h0199);
      for (int d = 0; d < 2; d++) begin
         regWr(10'h040, d ? 16'h0119 : 16'h0019);
         linkWait(8);
         pollAddr = 2'h3;
         linkWait(1);
         chk(16'(polled), 16'(d));
         linkWait(1);
         chk(16'(polled), 16'h0000);
         pollAddr = 2'h0;
      end
      regWr(10'h340, 16'h0119);
      $display("poll done");
   endtask : testPoll

   task automatic testSingle;
      int base;
      @(posedge clk) #1;
      quad = 1'b0;
      regWr(10'h040, 16'h0519);
      linkWait(10);
      chk(16'(polled), 16'h0000);
      // Parity traffic may still be draining; count from a settled base
      repeat (20) @(posedge clk);
      base = words[0];
      u_atm_writer_model.sendCell(2, 7, 0, 0, 1);
      waitWords(0, base + 7);
      chkCount(words[0], base + 7);
      chkCount(words[2], 7);
      $display("single mode done");
   endtask : testSingle

   task automatic final_report;
      $display("mismatches=%0d checks=%0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report

   // Reset for ten clocks, then let the link side come out of reset
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      linkWait(8);
      testRegs();
      testFlush();
      testFill();
      testSpacer();
      testParity();
      testPoll();
      testSingle();
      final_report();
   end
endmodule : tx_cell_if_channel_config_bench
